// ---- hdl/bkrc_defines.svh ----
// bkrc_defines.svh: offsets, reset values and timing counts for the buck control slice
// assumes a 200 MHz core clock; included by its bare name
`ifndef BKRC_DEFINES_SVH
`define BKRC_DEFINES_SVH
`define BKRC_NUM_REG        4
`define BKRC_CODE_W         6
`define BKRC_ADDR_W         4
// register index map of the serial byte interface
`define BKRC_OFS_CODE_LO    4'h0
`define BKRC_OFS_CODE_HI    4'h4
`define BKRC_OFS_ENABLE     4'h8
`define BKRC_OFS_UNMASK     4'h9
`define BKRC_OFS_STATUS     4'ha
// factory default codes (0x18 = 1.200 V step)
`define BKRC_CODE_RESET     6'h18
`define BKRC_ENABLE_RESET   4'hf
`define BKRC_UNMASK_RESET   4'h0
// soft-start ramp
`define BKRC_CLK_MHZ        200
`define BKRC_SOFTSTART_US   400
`define BKRC_SOFTSTART_CYC  (`BKRC_SOFTSTART_US * `BKRC_CLK_MHZ)
`endif

// ---- hdl/bkrc_pkg.sv ----
// bkrc_pkg: types shared by the buck control slice
// assumes bkrc_defines.svh sits on the include path
package bkrc_pkg;
    `include "bkrc_defines.svh"
    typedef logic [`BKRC_CODE_W-1:0] bkrc_code_t;
    typedef logic [`BKRC_ADDR_W-1:0] bkrc_addr_t;
    typedef enum logic [1:0] {BKRC_OFF, BKRC_RAMP, BKRC_ON} bkrc_state_e;
endpackage : bkrc_pkg

// ---- hdl/bkrc_buck_control.sv ----
// bkrc_buck_control: registers, code selection, soft-start and fault interrupt
// for four step-down regulators; a serial byte front end delivers single
// byte reads and writes as one-cycle strobes on the same clock
`timescale 1ns/1ps

`include "bkrc_defines.svh"

// Notes on behaviour
// [R1] regulators 1..3 use low-bank code when select pin low, high-bank when high
// [R2] codes are six bits: low three pick range, upper three pick step
// [R3] host writes each code independently once running; low bank vs high bank
// [R4] after reset codes hold factory defaults until the host writes
// [R5] each regulator runs or stops per its host-written enable bit
// [R6] power-good reads 0 while output below threshold, else 1
// [R7] unmasked regulator losing power-good raises the interrupt
// [R8] interrupt stays low until fault gone and status read
// [R9] every enable and fault recovery reruns a 400 us soft-start
// [R10] shared open-drain interrupt pulled low while any latch pending
// [R11] host uses single-byte reads and writes at slave address 1011010
// [R12] per-regulator pending latch, cleared by status read with fault gone
module bkrc_buck_control
    import bkrc_pkg::*;
#(
    parameter int unsigned SOFTSTART_CYC = `BKRC_SOFTSTART_CYC
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    // single byte register access from serial front end
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    input  wire bkrc_pkg::bkrc_addr_t         reg_addr,
    input  wire logic [7:0]                   reg_wdata,
    output logic [7:0]                        reg_rdata,
    // pins and analog comparators (asynchronous)
    input  wire logic [`BKRC_NUM_REG-1:0]     voltage_bank_select_pin,
    input  wire logic [`BKRC_NUM_REG-1:0]     below_threshold,
    input  wire logic [`BKRC_NUM_REG-1:0]     short_fault,
    // to analog regulators
    output logic [`BKRC_NUM_REG*`BKRC_CODE_W-1:0] regulator_voltage_code,
    output logic [`BKRC_NUM_REG-1:0]          regulator_run,
    output logic [`BKRC_NUM_REG-1:0]          soft_start_active,
    // open-drain interrupt
    output logic                              interrupt_out_n,
    output logic                              interrupt_out_oe
);
    import bkrc_pkg::*;

    localparam int N = `BKRC_NUM_REG;

    // host visible registers; both banks reset to the same factory code
    bkrc_code_t               voltage_code_low_bank  [N];
    bkrc_code_t               voltage_code_high_bank [N];
    logic [N-1:0]             enable;
    logic [N-1:0]             fault_interrupt_unmask;

    // one pending latch per regulator, ored onto the shared pin
    logic [N-1:0]             pending;

    // synchroniser stages for the select pins, comparators and short flags
    logic [N-1:0]             sel_s1, sel_s2, sel_s3;
    logic [N-1:0]             low_s1, low_s2, low_s3;
    logic [N-1:0]             flt_s1, flt_s2, flt_s3;

    // filtered levels; a single-cycle glitch never reaches these
    logic [N-1:0]             bank, below, fault;

    // status view and the set condition of the pending latches
    logic [N-1:0]             power_good;
    logic [N-1:0]             fault_seen;

    // soft-start sequencer; counter sized for any ramp length in cycles
    bkrc_state_e              state [N];
    logic [31:0]              ramp_cnt [N];

    // three stage synchronisers; change counts once stages two and three agree
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {sel_s1, sel_s2, sel_s3} <= '0;
            {low_s1, low_s2, low_s3} <= '0;
            {flt_s1, flt_s2, flt_s3} <= '0;
        end else begin
            {sel_s3, sel_s2, sel_s1} <= {sel_s2, sel_s1, voltage_bank_select_pin};
            {low_s3, low_s2, low_s1} <= {low_s2, low_s1, below_threshold};
            {flt_s3, flt_s2, flt_s1} <= {flt_s2, flt_s1, short_fault};
        end
    end

    // filtered levels, held until the two late stages agree
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bank  <= '0;
            below <= '0;
            fault <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (sel_s2[i] == sel_s3[i]) bank[i]  <= sel_s3[i];
                if (low_s2[i] == low_s3[i]) below[i] <= low_s3[i];
                if (flt_s2[i] == flt_s3[i]) fault[i] <= flt_s3[i];
            end
        end
    end

    // address decode shared by the write and read paths
    // the two low index bits pick the regulator inside a bank
    // the two high index bits pick low bank, high bank or control bytes
    wire [N-1:0] wr_lo_hit  = {N{reg_wr}} & (N'(1) << reg_addr[1:0]);
    wire         is_lo      = reg_addr[3:2] == 2'b00;
    wire         is_hi      = reg_addr[3:2] == 2'b01;
    wire         status_rd  = reg_rd && reg_addr == `BKRC_OFS_STATUS;

    // register writes; defaults hold until host writes      [R4]
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < N; i++) begin
                voltage_code_low_bank[i]  <= `BKRC_CODE_RESET;
                voltage_code_high_bank[i] <= `BKRC_CODE_RESET;
            end
            enable                 <= `BKRC_ENABLE_RESET;
            fault_interrupt_unmask <= `BKRC_UNMASK_RESET;
        end else if (reg_wr) begin
            for (int i = 0; i < N; i++) begin
                if (wr_lo_hit[i] && is_lo)
                    voltage_code_low_bank[i]  <= reg_wdata[5:0]; // [R3]
                if (wr_lo_hit[i] && is_hi)
                    voltage_code_high_bank[i] <= reg_wdata[5:0]; // [R3]
            end
            if (reg_addr == `BKRC_OFS_ENABLE) enable <= reg_wdata[N-1:0]; // [R5]
            if (reg_addr == `BKRC_OFS_UNMASK) fault_interrupt_unmask <= reg_wdata[N-1:0];
        end
    end

    // power-good is meaningful only once running and settled
    always_comb begin
        for (int i = 0; i < N; i++)
            power_good[i] = !below[i]; // [R6]
    end

    // soft-start sequencer per regulator; a short fault forces a fresh ramp
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < N; i++) begin
                state[i]    <= BKRC_OFF;
                ramp_cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                case (state[i])
                    BKRC_OFF: if (enable[i] && !fault[i]) begin
                        state[i]    <= BKRC_RAMP; // [R9]
                        ramp_cnt[i] <= '0;
                    end
                    BKRC_RAMP: begin
                        if (!enable[i] || fault[i]) state[i] <= BKRC_OFF;
                        else if (ramp_cnt[i] == SOFTSTART_CYC - 1) state[i] <= BKRC_ON;
                        else ramp_cnt[i] <= ramp_cnt[i] + 32'd1; // [R9]
                    end
                    BKRC_ON: if (!enable[i] || fault[i]) state[i] <= BKRC_OFF; // [R5]
                    default: state[i] <= BKRC_OFF;
                endcase
            end
        end
    end

    // fault seen only while settled; off regulators never raise
    always_comb begin
        for (int i = 0; i < N; i++)
            fault_seen[i] = state[i] == BKRC_ON && below[i] && fault_interrupt_unmask[i];
    end

    // pending latches; a new fault wins over a status read clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pending <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (fault_seen[i])
                    pending[i] <= 1'b1; // [R7] [R12]
                else if (status_rd && (state[i] != BKRC_ON || !below[i]))
                    pending[i] <= 1'b0; // [R8] [R12]
            end
        end
    end

    // code selection; regulator 0 has no pin and always uses the low bank
    // the bank follows the filtered pin, so a change lands a few cycles late
    // the host must write the bank that the pin currently selects
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (i != 0 && bank[i])
                regulator_voltage_code[i*`BKRC_CODE_W +: `BKRC_CODE_W] =
                    voltage_code_high_bank[i]; // [R1] [R2]
            else
                regulator_voltage_code[i*`BKRC_CODE_W +: `BKRC_CODE_W] =
                    voltage_code_low_bank[i];  // [R1]
            regulator_run[i]     = state[i] != BKRC_OFF;
            soft_start_active[i] = state[i] == BKRC_RAMP;
        end
    end

    // read data registered; unmapped reads give zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (is_lo)      reg_rdata <= {2'b00, voltage_code_low_bank[reg_addr[1:0]]};
            else if (is_hi) reg_rdata <= {2'b00, voltage_code_high_bank[reg_addr[1:0]]};
            else if (reg_addr == `BKRC_OFS_ENABLE) reg_rdata <= {4'h0, enable};
            else if (reg_addr == `BKRC_OFS_UNMASK) reg_rdata <= {4'h0, fault_interrupt_unmask};
            else if (status_rd) reg_rdata <= {pending, power_good}; // [R6]
            else reg_rdata <= 8'h00; // [R11]
        end
    end

    // open drain: pin driven low only while something pending
    // drive value is fixed low; the external pull-up makes the high level
    // so the enable alone decides whether the pin is pulled down
    assign interrupt_out_n  = 1'b0;
    assign interrupt_out_oe = |pending; // [R10]

endmodule : bkrc_buck_control

// ---- verification/bkrc_regulator_model.sv ----
// bkrc_regulator_model: comparator view of the four analog step-down stages
// assumes the bench requests a droop per regulator on the clock edge
`timescale 1ns/1ps
module bkrc_regulator_model (
    // control from the slice and the bench
    input  wire logic [3:0] regulator_run,
    input  wire logic [3:0] droop_req,
    // comparator outputs back to the slice
    output logic      [3:0] below_threshold
);
    // a stopped stage sits at ground, so it always reads under threshold
    assign below_threshold = droop_req | ~regulator_run;
endmodule : bkrc_regulator_model

// ---- verification/bkrc_buck_control_chk.sv ----
// bkrc_buck_control_chk: port-level assertions on the buck control slice
// assumes a short soft-start count handed on through the bind
`timescale 1ns/1ps
module bkrc_buck_control_chk
    import bkrc_pkg::*;
#(
    parameter int unsigned SOFTSTART_CYC = 20
) (
    // clock, reset and byte access
    input wire logic                 clk, sys_rst, reg_wr, reg_rd,
    input wire bkrc_pkg::bkrc_addr_t reg_addr,
    input wire logic [7:0]           reg_wdata, reg_rdata,
    // pins, comparators and regulator side
    input wire logic [3:0]           voltage_bank_select_pin, below_threshold, short_fault,
    input wire logic [23:0]          regulator_voltage_code,
    input wire logic [3:0]           regulator_run, soft_start_active,
    input wire logic                 interrupt_out_n, interrupt_out_oe
);
    localparam int SS_LO = SOFTSTART_CYC - 2;
    localparam int SS_HI = SOFTSTART_CYC + 2;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_OE_N: assert property (interrupt_out_n == 1'b0)
        else $error("interrupt drive value not low");
    AST_RD_ZERO: assert property (reg_rd && reg_addr > 4'ha |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_CODE_LO: assert property (reg_wr && reg_addr == 4'h1 && !voltage_bank_select_pin[1]
        && !$past(voltage_bank_select_pin[1], 6) |=>
        regulator_voltage_code[11:6] == $past(reg_wdata[5:0])) else $error("low bank code lost");
    AST_INT_CLEAR: assert property ($fell(interrupt_out_oe)
        |-> $past(reg_rd && reg_addr == 4'ha)) else $error("interrupt cleared without read");
    AST_RAMP_HOLD: assert property ($rose(soft_start_active[0]) |-> soft_start_active[0][*8])
        else $error("soft start cut short");
    AST_RAMP_END: assert property ($rose(soft_start_active[0]) |-> ##[SS_LO:SS_HI]
        !soft_start_active[0]) else $error("soft start too long");
    AST_RAMP_MIN: assert property ($fell(soft_start_active[0]) |->
        $past(soft_start_active[0], SS_LO)) else $error("soft start too short");
    AST_RUN_OFF: assert property (reg_wr && reg_addr == 4'h8 && !reg_wdata[1] |->
        ##[1:3] !regulator_run[1]) else $error("disabled regulator still runs");
    AST_RESET_CODE: assert property ($fell(sys_rst) |-> regulator_voltage_code == {4{6'h18}})
        else $error("codes not at default after reset");
endmodule : bkrc_buck_control_chk
bind bkrc_buck_control bkrc_buck_control_chk #(.SOFTSTART_CYC(SOFTSTART_CYC)) chk_u (
    .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .voltage_bank_select_pin(voltage_bank_select_pin),
    .below_threshold(below_threshold), .short_fault(short_fault),
    .regulator_voltage_code(regulator_voltage_code), .regulator_run(regulator_run),
    .soft_start_active(soft_start_active), .interrupt_out_n(interrupt_out_n),
    .interrupt_out_oe(interrupt_out_oe));

// ---- verification/tb.sv ----
// tb: directed register and pin sequences for the buck control slice
// assumes the regulator model closes the comparator loop
`timescale 1ns/1ps
module tb;
    import bkrc_pkg::*;
    localparam int unsigned SS = 20;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, oe, irq_n;
    bkrc_addr_t  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata;
    logic [3:0]  pins = 4'h0, droop = 4'h0, shorts = 4'h0, below, run, ssa;
    logic [23:0] codes;
    int          errors = 0, cmp_count = 0;
    always #2.5 clk = ~clk;
    bkrc_buck_control #(.SOFTSTART_CYC(SS)) dut_u (.clk(clk), .sys_rst(sys_rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .voltage_bank_select_pin(pins), .below_threshold(below),
        .short_fault(shorts), .regulator_voltage_code(codes), .regulator_run(run),
        .soft_start_active(ssa), .interrupt_out_n(irq_n), .interrupt_out_oe(oe));
    bkrc_regulator_model model_u (.regulator_run(run), .droop_req(droop), .below_threshold(below));
    task automatic cyc(input int n); repeat (n) @(posedge clk); endtask : cyc
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_flag(input logic got, input logic exp);
        #1 cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag
    task automatic chk_code(input int i, input bkrc_code_t e);
        #1 chk_byte({2'b00, codes[i*6 +: 6]}, {2'b00, e});
    endtask : chk_code
    // strobes held one edge; back-to-back calls are legal
    task automatic wr(input bkrc_addr_t a, input logic [7:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input bkrc_addr_t a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk_byte(reg_rdata, exp);
    endtask : rd_chk
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // watchdog: the sequence needs well under 1000 cycles
    initial begin
        #20000 errors++;
        give_verdict();
    end
    initial begin
        cyc(4);
        sys_rst <= 1'b0;
        cyc(2);
        for (int i = 0; i < 4; i++) chk_code(i, 6'h18);
        rd_chk(4'h8, 8'h0f);
        rd_chk(4'hb, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 4; i++) wr(4'(i), 8'(63 - i * 21));
        for (int i = 0; i < 4; i++) wr(4'(i + 4), 8'(i * 17 + 1));
        for (int i = 0; i < 4; i++) chk_code(i, 6'(63 - i * 21));
        cyc(1);
        pins <= 4'hf;
        cyc(8);
        for (int i = 1; i < 4; i++) chk_code(i, 6'(i * 17 + 1));
        chk_code(0, 6'h3f);
        wr(4'h5, 8'h3f);
        chk_code(1, 6'h3f);
        $display("test codes done");
        wr(4'h9, 8'h02);
        droop <= 4'h6;
        cyc(8);
        chk_flag(oe, 1'b1);
        chk_flag(irq_n, 1'b0);
        rd_chk(4'ha, 8'h29);
        cyc(3);
        chk_flag(oe, 1'b1);
        droop <= 4'h0;
        cyc(8);
        chk_flag(oe, 1'b1);
        rd_chk(4'ha, 8'h2f);
        cyc(2);
        chk_flag(oe, 1'b0);
        $display("test interrupt done");
        wr(4'h9, 8'h00);
        wr(4'h8, 8'h0d);
        cyc(3);
        chk_flag(run[1], 1'b0);
        wr(4'h8, 8'h0f);
        cyc(2);
        chk_flag(ssa[1], 1'b1);
        cyc(SS + 4);
        chk_flag(ssa[1], 1'b0);
        shorts <= 4'h8;
        cyc(8);
        chk_flag(run[3], 1'b0);
        shorts <= 4'h0;
        cyc(8);
        chk_flag(ssa[3], 1'b1);
        $display("test soft start done");
        give_verdict();
    end
endmodule : tb
